// [rtl/tcu_uart.v]
// Functional notes
// RULE_01: three channels, interrupt or dma requests
// RULE_02: 64-byte fifo each way per channel
// RULE_03: transmit start, 5-8 data, parity, stops
// RULE_04: receive same programmable frame format
// RULE_05: baud source bus, divided core, external
// RULE_06: write into fifo, shifter, serial out
// RULE_07: serial in to shifter, then fifo
// RULE_08: break holds output low one frame
// RULE_09: break waits for current character end
// RULE_10: resume data after break
// RULE_11: flags for overrun, parity, frame, break
// RULE_12: overrun when unread data is overrun
// RULE_13: parity error on parity mismatch
// RULE_14: frame error on bad stop bit
// RULE_15: break when input low whole frame
// RULE_16: timeout after three idle word times
// RULE_17: flow pins only on channels 0, 1
// RULE_18: auto flow sends only while clear
// RULE_19: ready asserted above 32 free bytes
// RULE_20: far end clears only when able
// RULE_21: manual ready bit without auto flow
// RULE_22: divide source by 16 and divisor+1
// RULE_23: loopback feeds transmit into receive
// RULE_24: receive request at trigger level
// RULE_25: error request when error reaches head
// RULE_26: idle high, start low, lsb first
`timescale 1ns/1ns
`include "tcu_map.vh"
module tcu_uart #(
  parameter       AW       = 8,
  parameter [7:0] CORE_DIV = 8'h02
) (
  input  wire          core_clk,
  input  wire          resetn,
  input  wire [AW-1:0] awaddr,
  input  wire          awvalid,
  output reg           awready,
  input  wire [31:0]   wdata,
  input  wire [3:0]    wstrb,
  input  wire          wvalid,
  output reg           wready,
  output reg  [1:0]    bresp,
  output reg           bvalid,
  input  wire          bready,
  input  wire [AW-1:0] araddr,
  input  wire          arvalid,
  output reg           arready,
  output reg  [31:0]   rdata,
  output reg  [1:0]    rresp,
  output reg           rvalid,
  input  wire          rready,
  input  wire [2:0]    serial_in_pin,
  output wire [2:0]    serial_out_pin,
  input  wire [1:0]    clear_to_transmit_in_n,
  output wire [1:0]    ready_to_receive_out_n,
  input  wire          external_baud_clock,
  output wire [2:0]    rx_irq,
  output wire [2:0]    tx_irq,
  output wire [2:0]    err_irq,
  output wire [2:0]    rx_dma_req,
  output wire [2:0]    tx_dma_req
);
  localparam [5:0] TS_IDLE = 6'h01, TS_START = 6'h02, TS_DATA = 6'h04;
  localparam [5:0] TS_PAR = 6'h08, TS_STOP = 6'h10, TS_BRK = 6'h20;
  localparam [5:0] RS_IDLE = 6'h01, RS_START = 6'h02, RS_DATA = 6'h04;
  localparam [5:0] RS_PAR = 6'h08, RS_STOP = 6'h10, RS_BRKW = 6'h20;

  // bits in a frame: start, data, optional parity, stops
  function [3:0] tcu_frame_bits;
    input [7:0] lfc;
    begin
      tcu_frame_bits = 4'h7 + {2'b00, lfc[1:0]} + {3'b000, lfc[`TCU_LFC_PAR]} + {3'b000, lfc[`TCU_LFC_STOP2]};
    end
  endfunction

  // parity bit over the active data bits
  function tcu_par;
    input [7:0] d;
    input [1:0] wl;
    input       even;
    begin
      tcu_par = ^(d & (8'hff >> (2'h3 - wl))) ^ !even;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  reg          rs1_r;
  reg          rs2_r;
  wire         rst_n = rs2_r;
  reg  [2:0]   rx_s1_r;
  reg  [2:0]   rx_s2_r;
  reg  [1:0]   cts_s1_r;
  reg  [1:0]   cts_s2_r;
  reg          ext_s1_r;
  reg          ext_s2_r;
  reg          ext_s3_r;
  reg  [7:0]   div_cnt_r;
  reg          div_tick_r;
  wire         ext_rise = ext_s2_r && !ext_s3_r;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end

  // idle levels preset so nothing looks like a start bit after reset
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_r  <= 3'h7;
      rx_s2_r  <= 3'h7;
      cts_s1_r <= 2'h3;
      cts_s2_r <= 2'h3;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      rx_s1_r  <= serial_in_pin;
      rx_s2_r  <= rx_s1_r;
      cts_s1_r <= clear_to_transmit_in_n;
      cts_s2_r <= cts_s1_r;
      ext_s1_r <= external_baud_clock;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // RULE_05 divided core source
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r  <= 8'h00;
      div_tick_r <= 1'b0;
    end else begin
      div_tick_r <= (div_cnt_r == CORE_DIV - 8'h01);
      div_cnt_r  <= (div_cnt_r == CORE_DIV - 8'h01) ? 8'h00 : div_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave, one write and one read in flight
  reg          aw_have_r;
  reg          w_have_r;
  reg  [7:0]   aw_addr_r;
  reg  [31:0]  w_data_r;
  reg  [3:0]   w_strb_r;
  wire [31:0]  rd_val [0:2];
  wire         wr_go  = aw_have_r && w_have_r && !bvalid;
  wire [1:0]   wr_ch  = aw_addr_r[7:6];
  wire [3:0]   wr_idx = aw_addr_r[5:2];
  wire         wr_ok  = (wr_ch != 2'h3) && (wr_idx <= `TCU_BDV);
  wire         rd_go  = arvalid && arready;
  wire [1:0]   rd_ch  = araddr[7:6];
  wire [3:0]   rd_idx = araddr[5:2];
  wire         rd_ok  = (rd_ch != 2'h3) && (rd_idx <= `TCU_BDV);

  // address and data are taken in either order, answered once both held
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `TCU_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_r <= awaddr[7:0];
        aw_have_r <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        w_have_r <= 1'b1;
        wready   <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? `TCU_OKAY : `TCU_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read data is captured at the address handshake; side effects fire there
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `TCU_OKAY;
    end else begin
      if (rd_go) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_ok ? rd_val[rd_ch] : 32'h0;
        rresp   <= rd_ok ? `TCU_OKAY : `TCU_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RULE_01 three channels, alike except that only the first two have flow pins
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : ch
      localparam [1:0] CH = g;
      reg  [7:0]  lfc_r;
      reg  [7:0]  chc_r;
      reg  [7:0]  fcr_r;
      reg  [7:0]  mdc_r;
      reg  [15:0] bdv_r;
      reg  [15:0] bcnt_r;
      reg         tick_r;
      reg  [5:0]  tst_r;
      reg  [7:0]  tsh_r;
      reg  [3:0]  tph_r;
      reg  [3:0]  tbit_r;
      reg         tpar_r;
      reg         txo_r;
      reg         pin_r;
      reg  [5:0]  rxs_r;
      reg  [7:0]  rsh_r;
      reg  [3:0]  rph_r;
      reg  [3:0]  rbit_r;
      reg         rzero_r;
      reg         rperr_r;
      reg         rpush_r;
      reg  [10:0] rword_r;
      reg  [3:0]  esr_r;
      reg  [9:0]  tocnt_r;
      reg         to_r;
      reg  [4:0]  req_r;
      reg  [31:0] rv;
      wire [10:0] rxq;
      wire [6:0]  rxn;
      wire        rx_full;
      wire        rx_empty;
      wire [7:0]  txq;
      wire [6:0]  txn;
      wire        tx_full;
      wire        tx_empty;
      wire        cts_ok;
      wire        wsel      = wr_go && wr_ok && (wr_ch == CH);
      wire        rsel      = rd_go && (rd_ch == CH);
      wire        fen       = fcr_r[`TCU_FCR_FEN];
      wire        loop      = chc_r[`TCU_CHC_LOOP];
      wire        even      = lfc_r[`TCU_LFC_EVEN];
      wire [1:0]  wl        = lfc_r[1:0];
      wire [3:0]  fbits     = tcu_frame_bits(lfc_r);
      wire [3:0]  last_bit  = {2'b00, wl} + 4'h4;
      wire [9:0]  to_lim    = {2'b00, fbits, 4'h0} + {1'b0, fbits, 5'h00};
      // RULE_23 loopback path
      wire        rin       = loop ? txo_r : rx_s2_r[g];
      // non-fifo mode behaves as a one-entry holding register
      wire        rx_full_e = fen ? rx_full : !rx_empty;
      wire        tx_full_e = fen ? tx_full : !tx_empty;
      wire        bit_end   = tick_r && (tph_r == `TCU_OVS_LAST);
      wire        mid       = tick_r && (rph_r == `TCU_OVS_MID);
      // receiver keeps its own bit clock; the transmitter phase sits at zero while idle
      wire        rbit_end  = tick_r && (rph_r == `TCU_OVS_LAST);
      wire        tx_idle   = (tst_r == TS_IDLE);
      wire        brk_go    = tx_idle && tick_r && chc_r[`TCU_CHC_BRK];
      wire        tx_go     = tx_idle && tick_r && !chc_r[`TCU_CHC_BRK] && !tx_empty && cts_ok;
      wire        tx_push   = wsel && (wr_idx == `TCU_TXD) && w_strb_r[0] && !tx_full_e;
      wire        rx_pop    = rsel && (rd_idx == `TCU_RXD);
      wire        rx_take   = rx_pop && !rx_empty;
      wire        rx_req    = fen ? ((rxn >= (7'h01 << {fcr_r[5:4], 1'b0})) || to_r) : !rx_empty;
      wire        tx_req    = fen ? (txn <= {fcr_r[7:6], 4'h0}) : tx_empty;
      wire        err_req   = chc_r[`TCU_CHC_ERRIE] && (((|rxq[10:8]) && !rx_empty) || (|esr_r));

      // RULE_02 receive buffer with error bits alongside each character
      tcu_fifo #(.W(11), .AW(6)) u_rxf (
        .clk(core_clk), .rst_n(rst_n), .clr(fcr_r[`TCU_FCR_RXRST]),
        .push(rpush_r && !rx_full_e), .din(rword_r), .pop(rx_pop),
        .dout(rxq), .count_r(rxn), .full(rx_full), .empty(rx_empty));
      // RULE_06 software writes land in the transmit buffer
      tcu_fifo #(.W(8), .AW(6)) u_txf (
        .clk(core_clk), .rst_n(rst_n), .clr(fcr_r[`TCU_FCR_TXRST]),
        .push(tx_push), .din(w_data_r[7:0]), .pop(tx_go),
        .dout(txq), .count_r(txn), .full(tx_full), .empty(tx_empty));

      // RULE_17 flow pins exist on the first two channels only
      if (g < 2) begin : fc
        reg rts_n_r;
        wire [6:0] free = `TCU_DEPTH - rxn;
        // RULE_18 sending gated by clear input
        // RULE_20 far end keeps clear honest
        assign cts_ok = !mdc_r[`TCU_MDC_AFC] || !cts_s2_r[g];
        // at exactly 32 free the previous level holds
        always @(posedge core_clk or negedge rst_n) begin
          if (!rst_n) begin
            rts_n_r <= 1'b1;
          end else if (mdc_r[`TCU_MDC_AFC]) begin
            // RULE_19 ready follows free space
            if (free > `TCU_RTS_FREE) rts_n_r <= 1'b0;
            else if (free < `TCU_RTS_FREE) rts_n_r <= 1'b1;
          end else begin
            // RULE_21 software ready bit
            rts_n_r <= !mdc_r[`TCU_MDC_RTS];
          end
        end
        assign ready_to_receive_out_n[g] = rts_n_r;
      end else begin : nofc
        assign cts_ok = 1'b1;
      end

      // control registers; a write of break wins over its self-clear
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          lfc_r <= `TCU_LFC_RST;
          chc_r <= `TCU_REG_RST;
          fcr_r <= `TCU_REG_RST;
          mdc_r <= `TCU_REG_RST;
          bdv_r <= `TCU_BDV_RST;
        end else begin
          fcr_r[`TCU_FCR_RXRST] <= 1'b0;
          fcr_r[`TCU_FCR_TXRST] <= 1'b0;
          if (brk_go) chc_r[`TCU_CHC_BRK] <= 1'b0;
          if (wsel && w_strb_r[0]) begin
            case (wr_idx)
              `TCU_LFC: lfc_r <= w_data_r[7:0];
              `TCU_CHC: chc_r <= w_data_r[7:0];
              `TCU_FCR: fcr_r <= w_data_r[7:0];
              `TCU_MDC: mdc_r <= w_data_r[7:0];
              `TCU_BDV: bdv_r[7:0] <= w_data_r[7:0];
              default: ;
            endcase
          end
          if (wsel && w_strb_r[1] && (wr_idx == `TCU_BDV)) bdv_r[15:8] <= w_data_r[15:8];
        end
      end

      // RULE_22 divisor+1 prescale; 16 ticks make one bit
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          bcnt_r <= 16'h0000;
          tick_r <= 1'b0;
        end else begin
          tick_r <= 1'b0;
          // RULE_05 source select
          if ((chc_r[`TCU_CHC_CSEL] == `TCU_CS_BUS) || (chc_r[`TCU_CHC_CSEL] == `TCU_CS_DIV && div_tick_r) ||
              (chc_r[`TCU_CHC_CSEL] == `TCU_CS_EXT && ext_rise)) begin
            tick_r <= (bcnt_r >= bdv_r);
            bcnt_r <= (bcnt_r >= bdv_r) ? 16'h0000 : bcnt_r + 16'h0001;
          end
        end
      end

      // transmitter; pin held high in loopback so the line stays idle
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          tst_r  <= TS_IDLE;
          tsh_r  <= 8'h00;
          tph_r  <= 4'h0;
          tbit_r <= 4'h0;
          tpar_r <= 1'b0;
          txo_r  <= 1'b1;
          pin_r  <= 1'b1;
        end else begin
          pin_r <= loop ? 1'b1 : txo_r;
          if (tick_r) tph_r <= tph_r + 4'h1;
          case (tst_r)
            TS_IDLE: begin
              tph_r <= 4'h0;
              // RULE_09 break only from idle
              if (brk_go) begin
                tst_r  <= TS_BRK;
                txo_r  <= 1'b0;
                tbit_r <= 4'h0;
              // RULE_10 data resumes after break
              end else if (tx_go) begin
                tst_r  <= TS_START;
                txo_r  <= 1'b0;
                tsh_r  <= txq;
                tpar_r <= tcu_par(txq, wl, even);
              end
            end
            TS_START: if (bit_end) begin
              // RULE_26 lsb first
              tst_r  <= TS_DATA;
              txo_r  <= tsh_r[0];
              tsh_r  <= {1'b0, tsh_r[7:1]};
              tbit_r <= 4'h0;
            end
            TS_DATA: if (bit_end) begin
              // RULE_03 data, parity, stop sequence
              if (tbit_r == last_bit) begin
                tst_r  <= lfc_r[`TCU_LFC_PAR] ? TS_PAR : TS_STOP;
                txo_r  <= lfc_r[`TCU_LFC_PAR] ? tpar_r : 1'b1;
                tbit_r <= 4'h0;
              end else begin
                txo_r  <= tsh_r[0];
                tsh_r  <= {1'b0, tsh_r[7:1]};
                tbit_r <= tbit_r + 4'h1;
              end
            end
            TS_PAR: if (bit_end) begin
              tst_r <= TS_STOP;
              txo_r <= 1'b1;
            end
            TS_STOP: if (bit_end) begin
              if (lfc_r[`TCU_LFC_STOP2] && tbit_r == 4'h0) tbit_r <= 4'h1;
              else tst_r <= TS_IDLE;
            end
            TS_BRK: if (bit_end) begin
              // RULE_08 low for one frame time
              if (tbit_r == fbits - 4'h1) begin
                tst_r <= TS_IDLE;
                txo_r <= 1'b1;
              end else begin
                tbit_r <= tbit_r + 4'h1;
              end
            end
            default: tst_r <= TS_IDLE;
          endcase
        end
      end

      // receiver samples mid-bit and resyncs on each start edge
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          rxs_r   <= RS_IDLE;
          rsh_r   <= 8'h00;
          rph_r   <= 4'h0;
          rbit_r  <= 4'h0;
          rzero_r <= 1'b0;
          rperr_r <= 1'b0;
          rpush_r <= 1'b0;
          rword_r <= 11'h000;
        end else begin
          rpush_r <= 1'b0;
          if (tick_r) rph_r <= rph_r + 4'h1;
          case (rxs_r)
            RS_IDLE: begin
              rph_r <= 4'h0;
              if (tick_r && !rin) rxs_r <= RS_START;
            end
            RS_START: begin
              if (mid && rin) rxs_r <= RS_IDLE;
              else if (rbit_end) begin
                rxs_r   <= RS_DATA;
                rbit_r  <= 4'h0;
                rsh_r   <= 8'h00;
                rzero_r <= 1'b1;
                rperr_r <= 1'b0;
              end
            end
            RS_DATA: begin
              // RULE_07 shift serial bits in
              if (mid) begin
                rsh_r   <= {rin, rsh_r[7:1]};
                rzero_r <= rzero_r && !rin;
              end
              if (rbit_end) begin
                // RULE_04 same programmable format
                if (rbit_r == last_bit) rxs_r <= lfc_r[`TCU_LFC_PAR] ? RS_PAR : RS_STOP;
                else rbit_r <= rbit_r + 4'h1;
              end
            end
            RS_PAR: begin
              if (mid) begin
                // RULE_13 parity mismatch
                rperr_r <= (rin != tcu_par(rsh_r, 2'h3, even));
                rzero_r <= rzero_r && !rin;
              end
              if (rbit_end) rxs_r <= RS_STOP;
            end
            RS_STOP: if (mid) begin
              // RULE_14 bad stop bit
              // RULE_15 all-low frame is a break
              rpush_r <= 1'b1;
              rword_r <= {rzero_r && !rin, !rin, rperr_r, rsh_r >> (2'h3 - wl)};
              rxs_r   <= (rzero_r && !rin) ? RS_BRKW : RS_IDLE;
            end
            RS_BRKW: if (rin) rxs_r <= RS_IDLE;
            default: rxs_r <= RS_IDLE;
          endcase
        end
      end

      // error flags, timeout and request outputs
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          esr_r   <= 4'h0;
          tocnt_r <= 10'h000;
          to_r    <= 1'b0;
          req_r   <= 5'h00;
        end else begin
          // RULE_11 sticky flags, read clears, set wins
          // RULE_12 overrun on push into full buffer
          esr_r <= ((rsel && rd_idx == `TCU_ERR) ? 4'h0 : esr_r) |
                   {rxq[10:8] & {3{rx_take}}, rpush_r && rx_full_e};
          // RULE_16 three word times of silence
          if (rpush_r || rx_pop || rx_empty || !fen) begin
            tocnt_r <= 10'h000;
            to_r    <= 1'b0;
          end else if (tick_r) begin
            if (tocnt_r == to_lim) to_r <= 1'b1;
            else tocnt_r <= tocnt_r + 10'h001;
          end
          // RULE_24 trigger level request
          // RULE_25 error request from head entry
          req_r <= {err_req, tx_req && chc_r[`TCU_CHC_TXDMA], tx_req && !chc_r[`TCU_CHC_TXDMA],
                    rx_req && chc_r[`TCU_CHC_RXDMA], rx_req && !chc_r[`TCU_CHC_RXDMA]};
        end
      end

      // register read view
      always @* begin
        rv = 32'h0;
        case (rd_idx)
          `TCU_LFC: rv = {24'h0, lfc_r};
          `TCU_CHC: rv = {24'h0, chc_r};
          `TCU_FCR: rv = {24'h0, fcr_r};
          `TCU_MDC: rv = {24'h0, mdc_r};
          `TCU_STA: rv = {9'h000, txn, 1'b0, rxn, 4'h0, to_r, tx_idle && tx_empty, tx_empty, !rx_empty};
          `TCU_ERR: rv = {28'h0, esr_r | {rxq[10:8] & {3{!rx_empty}}, 1'b0}};
          `TCU_RXD: rv = {24'h0, rxq[7:0]};
          `TCU_BDV: rv = {16'h0, bdv_r};
          default: rv = 32'h0;
        endcase
      end

      assign rd_val[g]         = rv;
      assign serial_out_pin[g] = pin_r;
      assign rx_irq[g]         = req_r[0];
      assign rx_dma_req[g]     = req_r[1];
      assign tx_irq[g]         = req_r[2];
      assign tx_dma_req[g]     = req_r[3];
      assign err_irq[g]        = req_r[4];
    end
  endgenerate
endmodule // tcu_uart

// [rtl/tcu_map.vh]
`ifndef TCU_MAP_VH
`define TCU_MAP_VH
// word index of each register inside a channel; byte address is ch*0x40 + idx*4
`define TCU_LFC        4'h0
`define TCU_CHC        4'h1
`define TCU_FCR        4'h2
`define TCU_MDC        4'h3
`define TCU_STA        4'h4
`define TCU_ERR        4'h5
`define TCU_TXD        4'h6
`define TCU_RXD        4'h7
`define TCU_BDV        4'h8
// line_format_control fields: [1:0] word length - 5
`define TCU_LFC_STOP2  2
`define TCU_LFC_PAR    3
`define TCU_LFC_EVEN   4
// channel_control fields
`define TCU_CHC_RXDMA  0
`define TCU_CHC_TXDMA  1
`define TCU_CHC_BRK    2
`define TCU_CHC_LOOP   3
`define TCU_CHC_CSEL   5:4
`define TCU_CHC_ERRIE  6
// fifo control fields
`define TCU_FCR_FEN    0
`define TCU_FCR_RXRST  1
`define TCU_FCR_TXRST  2
`define TCU_FCR_RXTRG  5:4
`define TCU_FCR_TXTRG  7:6
// modem_control fields
`define TCU_MDC_RTS    0
`define TCU_MDC_AFC    4
// clock source codes
`define TCU_CS_BUS     2'h0
`define TCU_CS_DIV     2'h1
`define TCU_CS_EXT     2'h2
// reset values
`define TCU_LFC_RST    8'h03
`define TCU_REG_RST    8'h00
`define TCU_BDV_RST    16'h0000
// timing
`define TCU_OVS_LAST   4'hf
`define TCU_OVS_MID    4'h7
`define TCU_RTS_FREE   7'h20
`define TCU_DEPTH      7'h40
// bus answers
`define TCU_OKAY       2'h0
`define TCU_SLVERR     2'h2
`endif

// [rtl/tcu_fifo.v]
`timescale 1ns/1ns
module tcu_fifo #(
  parameter W  = 11,
  parameter AW = 6
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          clr,
  input  wire          push,
  input  wire [W-1:0]  din,
  input  wire          pop,
  output wire [W-1:0]  dout,
  output reg  [AW:0]   count_r,
  output wire          full,
  output wire          empty
);
  localparam [AW:0] DEPTH = 1 << AW;
  reg  [W-1:0]  mem [0:DEPTH-1];
  reg  [AW-1:0] wp_r;
  reg  [AW-1:0] rp_r;
  wire          do_push = push && !full;
  wire          do_pop  = pop && !empty;

  assign full  = (count_r == DEPTH);
  assign empty = (count_r == {(AW+1){1'b0}});
  assign dout  = mem[rp_r];

  // storage carries no reset, only the pointers and fill level do
  always @(posedge clk) begin
    if (do_push) mem[wp_r] <= din;
  end

  // pointers and fill level; clear drops everything held
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r    <= {AW{1'b0}};
      rp_r    <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else if (clr) begin
      wp_r    <= {AW{1'b0}};
      rp_r    <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (do_push) wp_r <= wp_r + 1'b1;
      if (do_pop) rp_r <= rp_r + 1'b1;
      if (do_push && !do_pop) count_r <= count_r + 1'b1;
      else if (do_pop && !do_push) count_r <= count_r - 1'b1;
    end
  end
endmodule // tcu_fifo

// [testbench/tcu_uart_checker.sv]
`timescale 1ns/1ns
module tcu_chk (
  input logic       core_clk,
  input logic       resetn,
  input logic       awready,
  input logic       wready,
  input logic       bvalid,
  input logic       bready,
  input logic       arready,
  input logic       rvalid,
  input logic       rready,
  input logic [2:0] serial_out_pin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////
  // bus answers, tied to the capture that caused them
  AST_BLAT: assert property ($fell(awready) |-> ##[0:2] bvalid) else $error("late b");
  AST_BREF: assert property (bvalid |-> !awready && !wready) else $error("w open");
  AST_BEND: assert property (bvalid && bready |=> !bvalid && awready && wready) else $error("b stuck");
  AST_RLAT: assert property ($fell(arready) |-> rvalid) else $error("late r");
  AST_RREF: assert property (rvalid |-> !arready) else $error("ar open");
  AST_REND: assert property (rvalid && rready |=> !rvalid && arready) else $error("r stuck");
  // a bit is 16 ticks, never shorter than 8 cycles on any source
  AST_LOW: assert property ($fell(serial_out_pin[0]) |-> !serial_out_pin[0] [*8]) else $error("short 0");
  AST_HIGH: assert property ($rose(serial_out_pin[0]) |-> serial_out_pin[0] [*8]) else $error("short 1");
  C_TX: cover property ($fell(serial_out_pin[0]));
  C_WR: cover property (bvalid && bready);
  C_RD: cover property (rvalid && rready);
endmodule // tcu_chk
bind tcu_uart tcu_chk chk (.*);

// [testbench/tcu_peer.sv]
`timescale 1ns/1ns
module tcu_peer #(parameter int BT = 16) (
  input  logic       clk,
  input  logic       line_in,
  output logic       line_out,
  output logic [7:0] got,
  output int         n
);
  initial line_out = 1'b1;
  initial n = 0;
  ////////////////////////////////
  // idle high, lsb first
  task send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BT) @(posedge clk);
    end
    line_out <= 1'b1;
    @(posedge clk);
  endtask
  // mid-bit sampling keeps us clear of the edges the device drives on
  always begin
    @(negedge line_in);
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge clk);
      got[i] = line_in;
    end
    repeat (BT) @(posedge clk);
    n++;
  end
endmodule // tcu_peer

// [testbench/tb.sv]
`timescale 1ns/1ns
module tb;
  logic        core_clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, got;
  logic [31:0] wdata = 0;
  logic [1:0]  cts_n = 2'h0; // peer able to take data except while the flow test holds channel 0
  wire         awready, wready, bvalid, arready, rvalid, pl;
  wire [1:0]   bresp, rresp, ready_to_receive_out_n;
  wire [31:0]  rdata;
  wire [2:0]   serial_out_pin, ri;
  int          miscompares = 0, n_tests = 0, cyc = 0, pn;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d, e; logic [1:0] r;} tcu_row_t;
  tcu_row_t rows [5] = '{'{8'h00, 0, 0, 3, 0}, '{8'ha0, 1, 32'h1234, 32'h1234, 0}, '{8'h24, 0, 0, 0, 2},
                         '{8'hc0, 0, 0, 0, 2}, '{8'h58, 0, 0, 0, 0}};
  tcu_uart uut (.*, .wstrb(4'hf), .serial_in_pin({2'h3, pl}), .clear_to_transmit_in_n(cts_n),
    .external_baud_clock(1'b0), .rx_irq(ri), .tx_irq(), .err_irq(), .rx_dma_req(), .tx_dma_req());
  tcu_peer p (.clk(core_clk), .line_in(serial_out_pin[0]), .line_out(pl), .got(got), .n(pn));
  ////////////////////////////////
  initial forever #2 core_clk = ~core_clk;
  // a hang counts against the run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      give_verdict;
    end
  end
  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    chk(rdata, e);
    chk(rresp, r);
  endtask
  task give_verdict;
    $display("%0d checks, %0d bad", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // non-fifo mode throughout so one held byte can be overrun
  initial begin
    repeat (3) @(posedge core_clk);
    chk({ready_to_receive_out_n, serial_out_pin}, 32'h1f);
    resetn <= 1;
    repeat (2) @(posedge core_clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, rows[i].r);
    end
    $display("registers done");
    p.send(8'h3c, 1);
    p.send(8'hc3, 1);
    rd(8'h14, 1, 0);
    chk(ri[0], 1);
    rd(8'h1c, 8'h3c, 0);
    p.send(8'h55, 0);
    rd(8'h14, 4, 0);
    rd(8'h1c, 8'h55, 0);
    @(posedge core_clk) chk(ri[0], 0);
    $display("receive done");
    wr(8'h18, 8'ha5);
    wr(8'h04, 4);
    wait (pn == 1) chk(got, 8'ha5);
    wait (pn == 2) chk(got, 0);
    wr(8'h18, 8'h96);
    wait (pn == 3) chk(got, 8'h96);
    $display("transmit done");
    wr(8'h0c, 8'h10);
    @(posedge core_clk) chk(ready_to_receive_out_n[0], 0);
    cts_n <= 2'h1;
    wr(8'h18, 8'h77);
    repeat (400) @(posedge core_clk);
    chk(pn, 3);
    cts_n <= 2'h0;
    wait (pn == 4) chk(got, 8'h77);
    wr(8'h0c, 0);
    @(posedge core_clk) chk(ready_to_receive_out_n[0], 1);
    wr(8'h0c, 1);
    @(posedge core_clk) chk(ready_to_receive_out_n[0], 0);
    $display("flow done");
    // mid-run reset must drop every pin back to idle and clear the modem control register
    resetn <= 0;
    @(posedge core_clk) chk({ready_to_receive_out_n, serial_out_pin}, 32'h1f);
    resetn <= 1;
    repeat (2) @(posedge core_clk);
    rd(8'h0c, 0, 0);
    $display("reset done");
    give_verdict;
  end
endmodule // tb
